/* File: xfer_decode_pkg.sv */
// Purpose: constants and types for the data-transfer decode and timing
// Assumes: one clock; instruction bytes arrive from the bus interface unit
// Notes: cycle figures are minimum execution clocks of the wide variant
// Operation
// - opcode 10001110 plus addressing byte loads a segment register, 2/9 or 2/13.
// - opcode 10001100 plus addressing byte stores a segment register, 2/11 or 2/15.
// - opcode 11010111 looks up a table byte into accumulator low, 11 or 15.
// - opcode 10001101 loads an effective address, no memory access, 6 clocks.
// - opcode 11000101 memory form loads far pointer with data segment, 18/26.
// - opcode 11000100 memory form loads far pointer with extra segment, 18/26.
// - opcode 10011111 copies low flags into accumulator high byte, 2 clocks.
// - opcode 10011110 stores accumulator high byte into low flags, 3 clocks.
// - wide-bus variant queues up to 6 prefetched instruction bytes.
// - narrow-bus variant queues only 4 bytes, so execution may stall.
// - memory instructions may take one or two clocks beyond their minimum.
// - jump and call counts include fetching the destination opcode.
// - counts start only with all bytes queued, no waits, even word data.
// - narrow variant adds 4 clocks per word memory transfer.
package xfer_decode_pkg;
   localparam logic [7:0] OP_TO_SEG = 8'h8E;
   localparam logic [7:0] OP_FROM_SEG = 8'h8C;
   localparam logic [7:0] OP_TABLE = 8'hD7;
   localparam logic [7:0] OP_LEA = 8'h8D;
   localparam logic [7:0] OP_FAR_DATA = 8'hC5;
   localparam logic [7:0] OP_FAR_EXTRA = 8'hC4;
   localparam logic [7:0] OP_FLAGS_TO_AH = 8'h9F;
   localparam logic [7:0] OP_AH_TO_FLAGS = 8'h9E;
   // addressing byte layout
   localparam int MOD_MSB = 7;
   localparam int SEG_PAD_BIT = 5;
   localparam int RM_MSB = 2;
   localparam logic [1:0] MOD_NODISP = 2'h0;
   localparam logic [1:0] MOD_DISP8 = 2'h1;
   localparam logic [1:0] MOD_DISP16 = 2'h2;
   localparam logic [1:0] MOD_REG = 2'h3;
   localparam logic [2:0] RM_DIRECT = 3'h6;
   // minimum clocks, wide variant
   localparam logic [5:0] CYC_SEG_REG = 6'h02;
   localparam logic [5:0] CYC_TO_SEG_MEM = 6'h09;
   localparam logic [5:0] CYC_FROM_SEG_MEM = 6'h0B;
   localparam logic [5:0] CYC_TABLE = 6'h0B;
   localparam logic [5:0] CYC_LEA = 6'h06;
   localparam logic [5:0] CYC_FAR = 6'h12;
   localparam logic [5:0] CYC_FLAGS_TO_AH = 6'h02;
   localparam logic [5:0] CYC_AH_TO_FLAGS = 6'h03;
   localparam logic [5:0] WORD_XFER_EXTRA = 6'h04;
   localparam logic [5:0] SYNC_EXTRA_MAX = 6'h02;
   // queue depths
   localparam logic [2:0] QUEUE_DEPTH_WIDE = 3'h6;
   localparam logic [2:0] QUEUE_DEPTH_NARROW = 3'h4;
   // reset values
   localparam logic [5:0] CYC_RST = 6'h00;
   localparam logic [2:0] LEVEL_RST = 3'h0;
   localparam logic [2:0] PTR_RST = 3'h0;
   typedef enum logic [3:0] {
      K_NONE = 4'h0,
      K_TO_SEG = 4'h1,
      K_FROM_SEG = 4'h2,
      K_TABLE = 4'h3,
      K_LEA = 4'h4,
      K_FAR_DATA = 4'h5,
      K_FAR_EXTRA = 4'h6,
      K_FLAGS_TO_AH = 4'h7,
      K_AH_TO_FLAGS = 4'h8
   } insn_kind_t;
endpackage : xfer_decode_pkg

/* File: prefetch_queue.sv */
// Purpose: byte queue between the bus interface unit and the decoder
// Assumes: pops never exceed the current level
// Notes: usable depth shrinks to four on the narrow-bus variant
module prefetch_queue
   import xfer_decode_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic narrow_i,
   input wire logic push_valid_i,
   input wire logic [7:0] push_byte_i,
   output logic push_ready_o,
   input wire logic [2:0] pop_cnt_i,
   output logic [7:0] head_o,
   output logic [7:0] second_o,
   output logic [2:0] level_o
);
   logic [7:0] buf_r [6];
   logic [2:0] rd_r, rd_nxt, wr_r, wr_nxt, level_r, level_nxt, cap;
   logic ready_r, ready_nxt, push_ok;

   function automatic logic [2:0] wrap_add(input logic [2:0] p,
      input logic [2:0] n);
      logic [3:0] s;
      s = {1'b0, p} + {1'b0, n};
      if (s >= {1'b0, QUEUE_DEPTH_WIDE})
      begin
         s = s - {1'b0, QUEUE_DEPTH_WIDE};
      end
      return s[2:0];
   endfunction : wrap_add

   always_comb
   begin
      // queue depth per variant
      // depth per variant
      cap = narrow_i ? QUEUE_DEPTH_NARROW : QUEUE_DEPTH_WIDE;
      push_ok = push_valid_i && ready_r;
      wr_nxt = push_ok ? wrap_add(wr_r, 3'h1) : wr_r;
      rd_nxt = wrap_add(rd_r, pop_cnt_i);
      level_nxt = level_r + {2'h0, push_ok} - pop_cnt_i;
      ready_nxt = level_nxt < cap;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rd_r <= PTR_RST;
         wr_r <= PTR_RST;
         level_r <= LEVEL_RST;
         ready_r <= 1'b0;
      end
      else
      begin
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         level_r <= level_nxt;
         ready_r <= ready_nxt;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (push_ok)
      begin
         buf_r[wr_r] <= push_byte_i;
      end
   end

   assign push_ready_o = ready_r;
   assign head_o = buf_r[rd_r];
   assign second_o = buf_r[wrap_add(rd_r, 3'h1)];
   assign level_o = level_r;

   a_wide_depth_cap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      level_r <= 3'h6)
      else $error("queue holds more than six bytes");
   a_full_refuses_push: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      narrow_i && $stable(narrow_i) && level_r == 3'h4 |-> !ready_r)
      else $error("narrow queue accepts a fifth byte");
endmodule : prefetch_queue

/* File: xfer_decode.sv */
// Purpose: decode and time one group of data-transfer instructions
// Assumes: bus interface unit pushes bytes and acks memory on this clock
// Notes: busy_o stays high for exactly the clocks an instruction takes
module xfer_decode
   import xfer_decode_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic narrow_bus_i,
   input wire logic fetch_valid_i,
   input wire logic [7:0] fetch_byte_i,
   output logic fetch_ready_o,
   input wire logic mem_ack_i,
   output logic [2:0] queue_level_o,
   output logic busy_o,
   output logic [3:0] insn_kind_o,
   output logic mem_form_o,
   output logic done_o,
   output logic [5:0] cycles_o,
   output logic invalid_o
);
   typedef enum logic [2:0] {
      ST_FETCH = 3'b001,
      ST_EXEC = 3'b010,
      ST_SYNC = 3'b100
   } state_t;

   state_t state_r, state_nxt;
   insn_kind_t kind_r, kind_nxt, dec_kind;
   logic [5:0] cnt_r, cnt_nxt, taken_r, taken_nxt, cycles_r, cycles_nxt;
   logic mem_r, mem_nxt, done_r, done_nxt, invalid_r, invalid_nxt;
   logic busy_r, busy_nxt, narrow_s1_r, narrow_r, dec_mem;
   logic [2:0] pop_cnt, dec_len, q_level;
   logic [7:0] q_head, q_second;

   function automatic insn_kind_t kind_of(input logic [7:0] op);
      case (op)
         OP_TO_SEG: return K_TO_SEG;
         OP_FROM_SEG: return K_FROM_SEG;
         OP_TABLE: return K_TABLE;
         OP_LEA: return K_LEA;
         OP_FAR_DATA: return K_FAR_DATA;
         OP_FAR_EXTRA: return K_FAR_EXTRA;
         OP_FLAGS_TO_AH: return K_FLAGS_TO_AH;
         OP_AH_TO_FLAGS: return K_AH_TO_FLAGS;
         default: return K_NONE;
      endcase
   endfunction : kind_of

   function automatic logic has_modrm(input insn_kind_t k);
      return k == K_TO_SEG || k == K_FROM_SEG || k == K_LEA ||
         k == K_FAR_DATA || k == K_FAR_EXTRA;
   endfunction : has_modrm

   function automatic logic is_far(input insn_kind_t k);
      return k == K_FAR_DATA || k == K_FAR_EXTRA;
   endfunction : is_far

   // opcode, addressing byte and displacement must all be queued
   function automatic logic [2:0] insn_len(input insn_kind_t k,
      input logic [7:0] modrm);
      logic [2:0] n;
      n = 3'h1;
      if (has_modrm(k))
      begin
         case (modrm[MOD_MSB -: 2])
            MOD_DISP8: n = 3'h3;
            MOD_DISP16: n = 3'h4;
            MOD_NODISP: n = (modrm[RM_MSB:0] == RM_DIRECT) ? 3'h4 : 3'h2;
            default: n = 3'h2;
         endcase
      end
      return n;
   endfunction : insn_len

   function automatic logic is_illegal(input insn_kind_t k,
      input logic [7:0] modrm);
      logic bad;
      bad = (k == K_NONE);
      if (is_far(k) && modrm[MOD_MSB -: 2] == MOD_REG)
      begin
         bad = 1'b1;
      end
      if ((k == K_TO_SEG || k == K_FROM_SEG) && modrm[SEG_PAD_BIT])
      begin
         bad = 1'b1;
      end
      return bad;
   endfunction : is_illegal

   function automatic logic touches_mem(input insn_kind_t k,
      input logic [7:0] modrm);
      logic m;
      m = 1'b0;
      if (k == K_TABLE || is_far(k))
      begin
         m = 1'b1;
      end
      if ((k == K_TO_SEG || k == K_FROM_SEG) &&
         modrm[MOD_MSB -: 2] != MOD_REG)
      begin
         m = 1'b1;
      end
      return m;
   endfunction : touches_mem

   function automatic logic [5:0] min_cycles(input insn_kind_t k,
      input logic mem, input logic narrow);
      logic [5:0] c;
      logic [5:0] xfers;
      c = CYC_RST;
      xfers = is_far(k) ? 6'h02 : {5'h00, mem};
      case (k)
         K_TO_SEG: c = mem ? CYC_TO_SEG_MEM : CYC_SEG_REG;
         K_FROM_SEG: c = mem ? CYC_FROM_SEG_MEM : CYC_SEG_REG;
         K_TABLE: c = CYC_TABLE;
         K_LEA: c = CYC_LEA;
         K_FAR_DATA, K_FAR_EXTRA: c = CYC_FAR;
         K_FLAGS_TO_AH: c = CYC_FLAGS_TO_AH;
         K_AH_TO_FLAGS: c = CYC_AH_TO_FLAGS;
         default: c = CYC_RST;
      endcase
      if (narrow)
      begin
         c = c + xfers * WORD_XFER_EXTRA;
      end
      return c;
   endfunction : min_cycles

   prefetch_queue u_queue (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .narrow_i(narrow_r),
      .push_valid_i(fetch_valid_i),
      .push_byte_i(fetch_byte_i),
      .push_ready_o(fetch_ready_o),
      .pop_cnt_i(pop_cnt),
      .head_o(q_head),
      .second_o(q_second),
      .level_o(q_level)
   );

   always_comb
   begin
      state_nxt = state_r;
      kind_nxt = kind_r;
      mem_nxt = mem_r;
      cnt_nxt = cnt_r;
      taken_nxt = taken_r;
      cycles_nxt = cycles_r;
      done_nxt = 1'b0;
      invalid_nxt = 1'b0;
      pop_cnt = 3'h0;
      dec_kind = kind_of(q_head);
      dec_mem = touches_mem(dec_kind, q_second);
      dec_len = insn_len(dec_kind, q_second);
      case (state_r)
         ST_FETCH:
         begin
            if (q_level >= dec_len)
            begin
               pop_cnt = dec_len;
               if (is_illegal(dec_kind, q_second))
               begin
                  invalid_nxt = 1'b1;
               end
               else
               begin
                  state_nxt = ST_EXEC;
                  kind_nxt = dec_kind;
                  mem_nxt = dec_mem;
                  cnt_nxt = min_cycles(dec_kind, dec_mem, narrow_r) - 6'h01;
                  taken_nxt = 6'h01;
               end
            end
         end
         ST_EXEC:
         begin
            if (cnt_r != 6'h00)
            begin
               cnt_nxt = cnt_r - 6'h01;
               taken_nxt = taken_r + 6'h01;
            end
            else if (!mem_r || mem_ack_i)
            begin
               state_nxt = ST_FETCH;
               done_nxt = 1'b1;
               cycles_nxt = taken_r;
            end
            else
            begin
               state_nxt = ST_SYNC;
               cnt_nxt = SYNC_EXTRA_MAX - 6'h01;
               taken_nxt = taken_r + 6'h01;
            end
         end
         ST_SYNC:
         begin
            if (mem_ack_i || cnt_r == 6'h00)
            begin
               state_nxt = ST_FETCH;
               done_nxt = 1'b1;
               cycles_nxt = taken_r;
            end
            else
            begin
               cnt_nxt = cnt_r - 6'h01;
               taken_nxt = taken_r + 6'h01;
            end
         end
         default:
         begin
            state_nxt = ST_FETCH;
         end
      endcase
      busy_nxt = (state_nxt != ST_FETCH);
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_r <= ST_FETCH;
         kind_r <= K_NONE;
         mem_r <= 1'b0;
         cnt_r <= CYC_RST;
         taken_r <= CYC_RST;
         cycles_r <= CYC_RST;
         done_r <= 1'b0;
         invalid_r <= 1'b0;
         busy_r <= 1'b0;
         narrow_s1_r <= 1'b0;
         narrow_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         mem_r <= mem_nxt;
         cnt_r <= cnt_nxt;
         taken_r <= taken_nxt;
         cycles_r <= cycles_nxt;
         done_r <= done_nxt;
         invalid_r <= invalid_nxt;
         busy_r <= busy_nxt;
         narrow_s1_r <= narrow_bus_i;
         narrow_r <= narrow_s1_r;
      end
   end

   assign queue_level_o = q_level;
   assign busy_o = busy_r;
   assign insn_kind_o = kind_r;
   assign mem_form_o = mem_r;
   assign done_o = done_r;
   assign cycles_o = cycles_r;
   assign invalid_o = invalid_r;

   a_seg_load_count: assert property (@(posedge clk_i)
      disable iff (!rst_b_i) done_r && kind_r == K_TO_SEG |->
      (mem_r ? (cycles_r >= (narrow_r ? 6'd13 : 6'd9) &&
      cycles_r <= (narrow_r ? 6'd15 : 6'd11)) : cycles_r == 6'd2))
      else $error("segment load took wrong clock count");
   a_seg_store_count: assert property (@(posedge clk_i)
      disable iff (!rst_b_i) done_r && kind_r == K_FROM_SEG |->
      (mem_r ? (cycles_r >= (narrow_r ? 6'd15 : 6'd11) &&
      cycles_r <= (narrow_r ? 6'd17 : 6'd13)) : cycles_r == 6'd2))
      else $error("segment store took wrong clock count");
   a_table_count: assert property (@(posedge clk_i)
      disable iff (!rst_b_i) done_r && kind_r == K_TABLE |->
      mem_r && cycles_r >= (narrow_r ? 6'd15 : 6'd11) &&
      cycles_r <= (narrow_r ? 6'd17 : 6'd13))
      else $error("table lookup took wrong clock count");
   a_lea_six_clocks: assert property (@(posedge clk_i)
      disable iff (!rst_b_i) $rose(busy_r) && kind_r == K_LEA |->
      busy_r [*6] ##1 (!busy_r && done_r && !mem_r && cycles_r == 6'd6))
      else $error("address load not six clocks");
   a_far_reg_refused: assert property (@(posedge clk_i)
      disable iff (!rst_b_i) state_r == ST_FETCH && q_level >= 3'h2 &&
      (q_head == 8'hC5 || q_head == 8'hC4) && q_second[7:6] == 2'h3 |=>
      invalid_r && !busy_r)
      else $error("register-form far load not refused");
   a_far_count: assert property (@(posedge clk_i)
      disable iff (!rst_b_i) done_r && (kind_r == K_FAR_EXTRA ||
      kind_r == K_FAR_DATA) |-> cycles_r >= (narrow_r ? 6'd26 : 6'd18) &&
      cycles_r <= (narrow_r ? 6'd28 : 6'd20))
      else $error("far pointer load took wrong clock count");
   a_flags_to_ah: assert property (@(posedge clk_i)
      disable iff (!rst_b_i) $rose(busy_r) && kind_r == K_FLAGS_TO_AH |->
      ##1 busy_r ##1 (!busy_r && done_r && cycles_r == 6'd2))
      else $error("flags copy not two clocks");
   a_ah_to_flags: assert property (@(posedge clk_i)
      disable iff (!rst_b_i) done_r && kind_r == K_AH_TO_FLAGS |->
      cycles_r == 6'd3 && $past(busy_r, 3) && !$past(busy_r, 4))
      else $error("flags store not three clocks");
   a_sync_bounded: assert property (@(posedge clk_i)
      disable iff (!rst_b_i) state_r == ST_SYNC |->
      ##[1:2] state_r == ST_FETCH)
      else $error("memory handshake wait over two clocks");
   a_no_start_empty: assert property (@(posedge clk_i)
      disable iff (!rst_b_i) !busy_r && q_level == 3'h0 |=> !busy_r)
      else $error("execution started with empty queue");
endmodule : xfer_decode

/* File: biu_model.sv */
// Purpose: bus interface unit model that feeds bytes and answers memory
// Assumes: testbench queues bytes with put once reset is released
// Notes: idle byte lane toggles so stale data never looks valid
module biu_model
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic fetch_ready_i,
   input wire logic busy_i,
   input wire logic [5:0] ack_after_i,
   output logic fetch_valid_o,
   output logic [7:0] fetch_byte_o,
   output logic mem_ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q[$];
   logic [5:0] busy_cnt;

   task automatic put(input logic [7:0] b);
      q.push_back(b);
   endtask : put

   // one byte a clock, held until the queue takes it
   always @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         q.delete();
         fetch_valid_o <= 1'h0;
         fetch_byte_o <= 8'h00;
         busy_cnt <= 6'h00;
      end
      else
      begin
         if (fetch_valid_o && fetch_ready_i)
            void'(q.pop_front());
         if (q.size() != 0)
         begin
            fetch_valid_o <= 1'h1;
            fetch_byte_o <= q[0];
         end
         else
         begin
            fetch_valid_o <= 1'h0;
            fetch_byte_o <= ~fetch_byte_o;
         end
         busy_cnt <= busy_i ? busy_cnt + 6'h01 : 6'h00;
      end
   end

   // slow answer: ack only after ack_after_i busy clocks
   assign mem_ack_o = busy_i && (busy_cnt >= ack_after_i);
endmodule : biu_model

/* File: testbench.sv */
// Purpose: self-checking bench for the data-transfer decode block
// Assumes: bus model feeds bytes; strap changes only with queue empty
// Notes: table rows cover opcodes and variants, hand tests follow
module testbench
   import xfer_decode_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic nar;
      logic [31:0] b;
      logic [2:0] n;
      logic [3:0] kind;
      logic mem;
      logic [5:0] cyc;
      logic [5:0] ack;
   } row_t;
   localparam int NROWS = 24;
   localparam row_t ROWS [NROWS] = '{
      '{1'h0, 32'h8EC00000, 3'h2, 4'h1, 1'h0, 6'h02, 6'h00},
      '{1'h0, 32'h8E000000, 3'h2, 4'h1, 1'h1, 6'h09, 6'h00},
      '{1'h0, 32'h8C461200, 3'h3, 4'h2, 1'h1, 6'h0B, 6'h00},
      '{1'h0, 32'h8CC30000, 3'h2, 4'h2, 1'h0, 6'h02, 6'h00},
      '{1'h0, 32'hD7000000, 3'h1, 4'h3, 1'h1, 6'h0B, 6'h00},
      '{1'h0, 32'h8D863412, 3'h4, 4'h4, 1'h0, 6'h06, 6'h00},
      '{1'h0, 32'hC5063412, 3'h4, 4'h5, 1'h1, 6'h12, 6'h00},
      '{1'h0, 32'hC4070000, 3'h2, 4'h6, 1'h1, 6'h12, 6'h00},
      '{1'h0, 32'h9F000000, 3'h1, 4'h7, 1'h0, 6'h02, 6'h00},
      '{1'h0, 32'h9E000000, 3'h1, 4'h8, 1'h0, 6'h03, 6'h00},
      '{1'h0, 32'h8E000000, 3'h2, 4'h1, 1'h1, 6'h0A, 6'h09},
      '{1'h0, 32'h8E000000, 3'h2, 4'h1, 1'h1, 6'h0B, 6'h3F},
      '{1'h0, 32'h8D000000, 3'h2, 4'h4, 1'h0, 6'h06, 6'h3F},
      '{1'h1, 32'h8E000000, 3'h2, 4'h1, 1'h1, 6'h0D, 6'h00},
      '{1'h1, 32'h8E460100, 3'h3, 4'h1, 1'h1, 6'h0F, 6'h3F},
      '{1'h1, 32'h8C000000, 3'h2, 4'h2, 1'h1, 6'h0F, 6'h00},
      '{1'h1, 32'hD7000000, 3'h1, 4'h3, 1'h1, 6'h0F, 6'h00},
      '{1'h1, 32'h8D000000, 3'h2, 4'h4, 1'h0, 6'h06, 6'h00},
      '{1'h1, 32'hC5000000, 3'h2, 4'h5, 1'h1, 6'h1A, 6'h00},
      '{1'h1, 32'hC4063412, 3'h4, 4'h6, 1'h1, 6'h1A, 6'h00},
      '{1'h1, 32'h9F000000, 3'h1, 4'h7, 1'h0, 6'h02, 6'h00},
      '{1'h1, 32'h9E000000, 3'h1, 4'h8, 1'h0, 6'h03, 6'h00},
      '{1'h1, 32'h8EC00000, 3'h2, 4'h1, 1'h0, 6'h02, 6'h00},
      '{1'h1, 32'h8CC00000, 3'h2, 4'h2, 1'h0, 6'h02, 6'h00}
   };
   logic clk_i = 1'h0;
   logic rst_b_i = 1'h0;
   logic narrow_bus_i = 1'h0;
   logic [5:0] ack_after = 6'h00;
   logic fetch_valid_i;
   logic [7:0] fetch_byte_i;
   logic fetch_ready_o;
   logic mem_ack_i;
   logic [2:0] queue_level_o;
   logic busy_o;
   logic [3:0] insn_kind_o;
   logic mem_form_o;
   logic done_o;
   logic [5:0] cycles_o;
   logic invalid_o;
   int n_errors = 0;
   int num_checks = 0;
   int ticks = 0;
   logic [7:0] cur_run = 8'h00;
   logic [7:0] last_run = 8'h00;

   xfer_decode dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .narrow_bus_i(narrow_bus_i), .fetch_valid_i(fetch_valid_i),
      .fetch_byte_i(fetch_byte_i), .fetch_ready_o(fetch_ready_o),
      .mem_ack_i(mem_ack_i), .queue_level_o(queue_level_o),
      .busy_o(busy_o), .insn_kind_o(insn_kind_o),
      .mem_form_o(mem_form_o), .done_o(done_o), .cycles_o(cycles_o),
      .invalid_o(invalid_o));
   biu_model biu (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .fetch_ready_i(fetch_ready_o), .busy_i(busy_o),
      .ack_after_i(ack_after), .fetch_valid_o(fetch_valid_i),
      .fetch_byte_o(fetch_byte_i), .mem_ack_o(mem_ack_i));

   initial
   begin
      forever #4 clk_i = ~clk_i;
   end

   // length of the latest busy run
   always @(negedge clk_i)
   begin
      if (busy_o === 1'h1)
         cur_run = cur_run + 8'h01;
      else if (cur_run != 8'h00)
      begin
         last_run = cur_run;
         cur_run = 8'h00;
      end
   end

   task automatic print_verdict;
      if (n_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   always @(posedge clk_i)
   begin
      ticks++;
      if (ticks == 20000)
      begin
         n_errors++;
         print_verdict();
      end
   end

   task automatic chk(input string name, input logic [7:0] seen,
      input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk

   // hands the first n bytes of a word to the bus model, top byte first
   task automatic put_bytes(input logic [31:0] b, input int n);
      for (int k = 0; k < n; k++)
         biu.put(b[31 - 8 * k -: 8]);
   endtask : put_bytes

   task automatic set_strap(input logic nar, input logic [5:0] ack);
      @(posedge clk_i);
      narrow_bus_i <= nar;
      ack_after <= ack;
      repeat (3) @(posedge clk_i);
   endtask : set_strap

   task automatic run(input row_t r);
      int k;
      bit got;
      set_strap(r.nar, r.ack);
      put_bytes(r.b, r.n);
      got = 1'b0;
      for (k = 0; k < 100 && !got; k++)
      begin
         @(negedge clk_i);
         got = (done_o === 1'h1);
      end
      chk("done", 8'(got), 8'h01);
      chk("kind", 8'(insn_kind_o), 8'(r.kind));
      chk("mem_form", 8'(mem_form_o), 8'(r.mem));
      chk("cycles", 8'(cycles_o), 8'(r.cyc));
      @(negedge clk_i);
      chk("busy_len", last_run, 8'(r.cyc));
   endtask : run

   task automatic expect_invalid(input logic [15:0] ins);
      int k;
      bit inv;
      bit bsy;
      biu.put(ins[15:8]);
      biu.put(ins[7:0]);
      inv = 1'b0;
      bsy = 1'b0;
      for (k = 0; k < 12; k++)
      begin
         @(negedge clk_i);
         inv = inv | (invalid_o === 1'h1);
         bsy = bsy | (busy_o !== 1'h0);
      end
      chk("invalid", 8'(inv), 8'h01);
      chk("busy_on_invalid", 8'(bsy), 8'h00);
   endtask : expect_invalid

   task automatic fill(input logic nar, input logic [2:0] depth);
      int k;
      int nd;
      logic [2:0] top;
      bit full;
      set_strap(nar, 6'h00);
      put_bytes(32'hC5063412, 4);
      for (k = 0; k < depth; k++)
         put_bytes(32'h9F000000, 1);
      top = 3'h0;
      full = 1'b0;
      nd = 0;
      for (k = 0; k < 200 && nd <= depth; k++)
      begin
         @(negedge clk_i);
         if (queue_level_o > top)
            top = queue_level_o;
         full = full | (fetch_ready_o === 1'h0);
         if (done_o === 1'h1)
         begin
            if (nd > 0)
               chk("queued_cycles", 8'(cycles_o), 8'h02);
            nd++;
         end
      end
      chk("queue_top", 8'(top), 8'(depth));
      chk("ready_drop", 8'(full), 8'h01);
      chk("queued_done", 8'(nd), 8'(depth + 1));
   endtask : fill

   initial
   begin
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      chk("rst_ready", 8'(fetch_ready_o), 8'h00);
      chk("rst_level", 8'(queue_level_o), 8'h00);
      @(posedge clk_i);
      rst_b_i <= 1'h1;
      repeat (2) @(negedge clk_i);
      chk("ready_after_rst", 8'(fetch_ready_o), 8'h01);
      for (int i = 0; i < NROWS; i++)
         run(ROWS[i]);
      set_strap(1'h0, 6'h00);
      expect_invalid(16'hC5C0);
      expect_invalid(16'hC4C1);
      expect_invalid(16'h8E20);
      expect_invalid(16'h0000);
      fill(1'h0, 3'h6);
      fill(1'h1, 3'h4);
      set_strap(1'h0, 6'h3F);
      put_bytes(32'hC5060010, 4);
      repeat (10) @(negedge clk_i);
      chk("busy_before_rst", 8'(busy_o), 8'h01);
      @(posedge clk_i);
      rst_b_i <= 1'h0;
      @(negedge clk_i);
      chk("rst_busy", 8'(busy_o), 8'h00);
      chk("rst_ready2", 8'(fetch_ready_o), 8'h00);
      chk("rst_kind", 8'(insn_kind_o), 8'h00);
      @(posedge clk_i);
      rst_b_i <= 1'h1;
      repeat (2) @(negedge clk_i);
      chk("ready_after_rst2", 8'(fetch_ready_o), 8'h01);
      run(ROWS[9]);
      print_verdict();
   end
endmodule : testbench
